//--- src/coproc_core_end.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module coproc_core_end
  import coproc_xfer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  coproc_link_if.core      link
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} state_t;

  state_t      state_ff;
  logic [31:0] coreRegs [16];
  logic [31:0] pc_ff;
  logic [3:0]  flags_ff;
  logic [3:0]  status_ff;
  logic [3:0]  regIdx_ff;
  logic [31:0] xAddr_ff;
  logic [31:0] instr_ff;
  logic [7:0]  waitCnt_ff;
  logic        waitReq_ff;
  logic [31:0] readData_ff;
  logic        issueValid_ff;

  logic        condPass;
  logic        isRegXfer;
  logic        isMemXfer;
  logic [31:0] wordOffs;
  logic [31:0] memBase;
  logic [31:0] modBase;
  logic [31:0] coreSrc;
  logic        access;
  logic        instrWrite;
  logic        finish;
  logic [31:0] nxt_readData;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  cond_check cond_check_inst (
    .cond  (avs_writedata[COND_HI:COND_LO]),
    .flags (flags_ff),
    .pass  (condPass)
  );

  // ----------------------------------------------------------------
  // decode of the instruction offered on the bus
  // ----------------------------------------------------------------
  assign isRegXfer = (avs_writedata[CLASS_HI:CLASS_LO] == REG_CLASS)
                   && avs_writedata[MARK_BIT];
  assign isMemXfer = (avs_writedata[CLASS_HI:MEM_CLASS_LO] == MEM_CLASS);
  assign wordOffs  = {22'h000000, avs_writedata[OFFS_HI:OFFS_LO], 2'h0};
  assign memBase   = (avs_writedata[PRIM_HI:PRIM_LO] == PC_INDEX)
                   ? pc_ff + PC_BASE_ADJ
                   : coreRegs[avs_writedata[PRIM_HI:PRIM_LO]];
  assign modBase   = avs_writedata[UP_BIT] ? memBase + wordOffs : memBase - wordOffs;
  assign coreSrc   = (avs_writedata[CORE_HI:CORE_LO] == PC_INDEX)
                   ? pc_ff + PC_STORE_ADJ
                   : coreRegs[avs_writedata[CORE_HI:CORE_LO]];

  assign access     = (avs_read || avs_write) && waitReq_ff;
  assign instrWrite = avs_write && (avs_address == ADDR_INSTR) && waitReq_ff;
  // an instruction write is held off until its transfer has finished
  assign finish     = (state_ff == S_DONE);

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= S_IDLE;
      waitCnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        S_IDLE: begin
          waitCnt_ff <= 8'h00;
          if (instrWrite) begin
            if (condPass && (isRegXfer || isMemXfer)) begin
              state_ff <= S_WAIT;
            end else begin
              state_ff <= S_DONE;
            end
          end
        end
        S_WAIT: begin
          waitCnt_ff <= waitCnt_ff + 8'h01;
          if (link.ack || (waitCnt_ff == NOACK_LIMIT)) begin
            state_ff <= S_DONE;
          end
        end
        S_DONE:  state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      issueValid_ff <= 1'b0;
      instr_ff      <= 32'h0000_0000;
      xAddr_ff      <= 32'h0000_0000;
      link.wrData   <= 32'h0000_0000;
    end else if (state_ff == S_IDLE && instrWrite) begin
      instr_ff      <= avs_writedata;
      issueValid_ff <= condPass && (isRegXfer || isMemXfer);
      link.wrData   <= coreSrc;
      xAddr_ff      <= avs_writedata[PREIDX_BIT] ? modBase : memBase;
    end else if (state_ff == S_WAIT && (link.ack || waitCnt_ff == NOACK_LIMIT)) begin
      issueValid_ff <= 1'b0;
    end
  end

  assign link.issueValid = issueValid_ff;
  assign link.memXfer    = (instr_ff[CLASS_HI:MEM_CLASS_LO] == MEM_CLASS);
  assign link.dirToCore  = instr_ff[DIR_BIT];
  assign link.unitSel    = instr_ff[NUM_HI:NUM_LO];
  assign link.opcode     = instr_ff[OPC_HI:OPC_LO];
  assign link.primReg    = instr_ff[PRIM_HI:PRIM_LO];
  assign link.info       = instr_ff[INFO_HI:INFO_LO];
  assign link.secReg     = instr_ff[SEC_HI:SEC_LO];
  assign link.longXfer   = instr_ff[LONG_BIT];
  assign link.memAddr    = xAddr_ff;

  // ----------------------------------------------------------------
  // core register file: bus access, loads from the coprocessor, write-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state_ff == S_IDLE && instrWrite && condPass && isMemXfer
        && avs_writedata[WBACK_BIT] && avs_writedata[PRIM_HI:PRIM_LO] != PC_INDEX) begin
      coreRegs[avs_writedata[PRIM_HI:PRIM_LO]] <= modBase;
    end else if (state_ff == S_WAIT && link.ack && !link.memXfer && link.dirToCore
                 && instr_ff[CORE_HI:CORE_LO] != PC_INDEX) begin
      coreRegs[instr_ff[CORE_HI:CORE_LO]] <= link.rdData;
    end else if (avs_write && waitReq_ff && avs_address == ADDR_REGDATA) begin
      coreRegs[regIdx_ff] <= merge(coreRegs[regIdx_ff], avs_writedata, avs_byteenable);
    end
  end

  // flags: a load to the counter replaces only the condition flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= 4'h0;
    end else if (state_ff == S_WAIT && link.ack && !link.memXfer && link.dirToCore
                 && instr_ff[CORE_HI:CORE_LO] == PC_INDEX) begin
      flags_ff <= link.rdData[FLAG_HI:FLAG_LO];
    end else if (avs_write && waitReq_ff && avs_address == ADDR_FLAGS && avs_byteenable[0]) begin
      flags_ff <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_ff <= 4'h0;
    end else if (state_ff == S_IDLE && instrWrite) begin
      status_ff           <= 4'h0;
      status_ff[ST_SKIP]  <= !condPass;
      status_ff[ST_UNDEF] <= condPass && !isRegXfer && !isMemXfer;
    end else if (state_ff == S_WAIT && link.ack) begin
      status_ff[ST_EXEC] <= 1'b1;
    end else if (state_ff == S_WAIT && waitCnt_ff == NOACK_LIMIT) begin
      status_ff[ST_NOACK] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff     <= PC_RESET;
      regIdx_ff <= 4'h0;
    end else if (avs_write && waitReq_ff) begin
      if (avs_address == ADDR_PC) begin
        pc_ff <= merge(pc_ff, avs_writedata, avs_byteenable);
      end
      if (avs_address == ADDR_REGIDX && avs_byteenable[0]) begin
        regIdx_ff <= avs_writedata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave: every access waits at least one cycle, an instruction until done
  // ----------------------------------------------------------------
  always_comb begin
    case (avs_address)
      ADDR_INSTR:   nxt_readData = instr_ff;
      ADDR_PC:      nxt_readData = pc_ff;
      ADDR_FLAGS:   nxt_readData = {28'h0000000, flags_ff};
      ADDR_STATUS:  nxt_readData = {28'h0000000, status_ff};
      ADDR_REGIDX:  nxt_readData = {28'h0000000, regIdx_ff};
      ADDR_REGDATA: nxt_readData = coreRegs[regIdx_ff];
      ADDR_XADDR:   nxt_readData = xAddr_ff;
      default:      nxt_readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitReq_ff  <= 1'b1;
      readData_ff <= 32'h0000_0000;
    end else if (!waitReq_ff) begin
      waitReq_ff <= 1'b1;
    end else if (access && (!instrWrite || finish)) begin
      waitReq_ff  <= (instrWrite && !finish);
      readData_ff <= avs_read ? nxt_readData : readData_ff;
    end
  end

  assign avs_waitrequest = waitReq_ff;
  assign avs_readdata    = readData_ff;
endmodule
`default_nettype wire

//--- src/coproc_xfer_pkg.sv
package coproc_xfer_pkg;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam int          COND_HI      = 31;
  localparam int          COND_LO      = 28;
  localparam int          CLASS_HI     = 27;
  localparam int          CLASS_LO     = 24;
  localparam int          MEM_CLASS_LO = 25;
  localparam int          PREIDX_BIT   = 24;
  localparam int          UP_BIT       = 23;
  localparam int          LONG_BIT     = 22;
  localparam int          OPC_HI       = 23;
  localparam int          OPC_LO       = 21;
  localparam int          WBACK_BIT    = 21;
  localparam int          DIR_BIT      = 20;
  localparam int          PRIM_HI      = 19;
  localparam int          PRIM_LO      = 16;
  localparam int          CORE_HI      = 15;
  localparam int          CORE_LO      = 12;
  localparam int          NUM_HI       = 11;
  localparam int          NUM_LO       = 8;
  localparam int          INFO_HI      = 7;
  localparam int          INFO_LO      = 5;
  localparam int          MARK_BIT     = 4;
  localparam int          SEC_HI       = 3;
  localparam int          SEC_LO       = 0;
  localparam int          OFFS_HI      = 7;
  localparam int          OFFS_LO      = 0;
  localparam logic [3:0]  REG_CLASS    = 4'hE;
  localparam logic [2:0]  MEM_CLASS    = 3'h6;
  localparam logic [3:0]  PC_INDEX     = 4'hF;
  localparam int          FLAG_HI      = 31;
  localparam int          FLAG_LO      = 28;

  // ----------------------------------------------------------------
  // pipeline offsets of the program counter
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_BASE_ADJ  = 32'h0000_0008;
  localparam logic [31:0] PC_STORE_ADJ = 32'h0000_000C;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_INSTR   = 5'h00;
  localparam logic [4:0]  ADDR_PC      = 5'h04;
  localparam logic [4:0]  ADDR_FLAGS   = 5'h08;
  localparam logic [4:0]  ADDR_STATUS  = 5'h0C;
  localparam logic [4:0]  ADDR_REGIDX  = 5'h10;
  localparam logic [4:0]  ADDR_REGDATA = 5'h14;
  localparam logic [4:0]  ADDR_XADDR   = 5'h18;

  localparam int          ST_EXEC      = 0;
  localparam int          ST_SKIP      = 1;
  localparam int          ST_UNDEF     = 2;
  localparam int          ST_NOACK     = 3;

  localparam logic [31:0] PC_RESET     = 32'h0000_0000;
  localparam logic [7:0]  NOACK_LIMIT  = 8'h10;

  typedef enum logic [2:0] {
    COND_OP_EQ, COND_OP_CS, COND_OP_MI, COND_OP_VS,
    COND_OP_HI, COND_OP_GE, COND_OP_GT, COND_OP_AL
  } cond_op_t;

endpackage

//--- src/coproc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface coproc_link_if;
  logic        issueValid;
  logic        memXfer;
  logic        dirToCore;
  logic [3:0]  unitSel;
  logic [2:0]  opcode;
  logic [3:0]  primReg;
  logic [2:0]  info;
  logic [3:0]  secReg;
  logic        longXfer;
  logic [31:0] memAddr;
  logic [31:0] wrData;
  logic        ack;
  logic [31:0] rdData;

  modport core (
    output issueValid, memXfer, dirToCore, unitSel, opcode, primReg, info, secReg,
    output longXfer, memAddr, wrData,
    input  ack, rdData
  );
  modport cop (
    input  issueValid, memXfer, dirToCore, unitSel, opcode, primReg, info, secReg,
    input  longXfer, memAddr, wrData,
    output ack, rdData
  );
endinterface
`default_nettype wire

//--- src/cond_check.sv
`timescale 1ns/1ps
`default_nettype none
module cond_check
  import coproc_xfer_pkg::*;
(
  input  wire logic [3:0] cond,
  input  wire logic [3:0] flags,
  output logic            pass
);
  logic n;
  logic z;
  logic c;
  logic v;
  logic base;

  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];

  // even codes test a relation, odd codes its inverse; the top two codes run always
  always_comb begin
    case (cond_op_t'(cond[3:1]))
      COND_OP_EQ: base = z;
      COND_OP_CS: base = c;
      COND_OP_MI: base = n;
      COND_OP_VS: base = v;
      COND_OP_HI: base = c & ~z;
      COND_OP_GE: base = (n == v);
      COND_OP_GT: base = ~z & (n == v);
      COND_OP_AL: base = 1'b1;
      default:    base = 1'b1;
    endcase
    pass = (cond[3:1] == 3'h7) ? 1'b1 : (base ^ cond[0]);
  end
endmodule
`default_nettype wire

//--- src/coproc_unit_end.sv
`timescale 1ns/1ps
`default_nettype none
module coproc_unit_end
  import coproc_xfer_pkg::*;
#(
  parameter logic [3:0] UNIT_NUMBER = 4'h1
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        presetWrite,
  input  wire logic [3:0]  presetIndex,
  input  wire logic [31:0] presetData,
  output logic             opStrobe,
  output logic             opMem,
  output logic             opToCore,
  output logic [2:0]       opCode,
  output logic [2:0]       opInfo,
  output logic [3:0]       opPrimReg,
  output logic [3:0]       opSecReg,
  output logic             opLong,
  output logic [31:0]      opAddr,
  output logic [31:0]      opData,
  coproc_link_if.cop       link
);
  logic [31:0] unitRegs [16];
  logic        ack_ff;
  logic [31:0] rdData_ff;
  logic        take;

  // ack is one cycle; blocking a second ack covers the core dropping valid late
  assign take = link.issueValid && (link.unitSel == UNIT_NUMBER) && !ack_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff    <= 1'b0;
      rdData_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      if (take && !link.memXfer && link.dirToCore) begin
        rdData_ff <= unitRegs[link.primReg];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (take && !link.memXfer && !link.dirToCore) begin
      unitRegs[link.primReg] <= link.wrData;
    end else if (presetWrite) begin
      unitRegs[presetIndex] <= presetData;
    end
  end

  // operation report for the unit's own datapath
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opStrobe  <= 1'b0;
      opMem     <= 1'b0;
      opToCore  <= 1'b0;
      opCode    <= 3'h0;
      opInfo    <= 3'h0;
      opPrimReg <= 4'h0;
      opSecReg  <= 4'h0;
      opLong    <= 1'b0;
      opAddr    <= 32'h0000_0000;
      opData    <= 32'h0000_0000;
    end else begin
      opStrobe <= take;
      if (take) begin
        opMem     <= link.memXfer;
        opToCore  <= link.dirToCore;
        opCode    <= link.opcode;
        opInfo    <= link.info;
        opPrimReg <= link.primReg;
        opSecReg  <= link.secReg;
        opLong    <= link.longXfer;
        opAddr    <= link.memAddr;
        opData    <= link.wrData;
      end
    end
  end

  assign link.ack    = ack_ff;
  assign link.rdData = rdData_ff;
endmodule
`default_nettype wire

//--- sim/coproc_transfer_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module coproc_transfer_decode_assertions
  import coproc_xfer_pkg::*;
#(
  parameter logic [3:0] UNIT_NUMBER = 4'h1
)
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        issueValid,
  input wire logic        memXfer,
  input wire logic        dirToCore,
  input wire logic [3:0]  unitSel,
  input wire logic [2:0]  opcode,
  input wire logic [3:0]  primReg,
  input wire logic [2:0]  info,
  input wire logic [3:0]  secReg,
  input wire logic        longXfer,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] wrData,
  input wire logic        ack,
  input wire logic [31:0] rdData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // issue phases
  // ----------------------------------------------------------------
  sequence issueStart;
    $rose(issueValid);
  endsequence
  sequence ownIssue;
    $rose(issueValid) && unitSel == UNIT_NUMBER;
  endsequence
  sequence ackSoon;
    ##[1:8] ack;
  endsequence
  // no-answer timeout is 16 cycles plus a few of wind-down
  sequence issueOver;
    ##[1:24] !issueValid;
  endsequence

  AST_ISSUE_HELD: assert property (issueValid && !ack && unitSel == UNIT_NUMBER |=> issueValid)
    else $error("issue dropped before answer");
  AST_SINGLE_EXCHANGE: assert property (ack |=> !issueValid && !ack)
    else $error("exchange not closed after answer");
  AST_FIELDS_STABLE: assert property (issueValid && !$rose(issueValid) |->
    $stable({dirToCore, memXfer, unitSel, opcode, primReg, info, secReg}))
    else $error("coprocessor fields moved during issue");
  AST_WORD_STABLE: assert property (issueValid && !$rose(issueValid) |->
    $stable({longXfer, memAddr, wrData}))
    else $error("word, address or length moved during issue");
  AST_ACK_OWN_NUMBER: assert property (ack |-> issueValid && unitSel == UNIT_NUMBER)
    else $error("answer to a foreign unit number");
  AST_ACK_IN_TIME: assert property (ownIssue |-> ackSoon)
    else $error("selected unit did not answer");
  AST_ISSUE_BOUNDED: assert property (issueStart |-> issueOver)
    else $error("issue never ended");
  AST_RDDATA_HELD: assert property (ack |=> $stable(rdData))
    else $error("returned word not held");
  AST_NO_ACK_IDLE: assert property (!issueValid |-> !ack)
    else $error("answer without issue");
endmodule
`default_nettype wire

//--- sim/tb_coproc_transfer_decode.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_coproc_transfer_decode
  import coproc_xfer_pkg::*;
;
  localparam logic [3:0] UNIT = 4'h1;
  // flags 9 (N and V set): pass pattern of the condition table below
  localparam logic [3:0] CONDS [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'hE};
  localparam logic [7:0] PASSES    = 8'hB6;
  logic        clk;
  logic        resetn;
  logic [4:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        presetWrite;
  logic [3:0]  presetIndex;
  logic [31:0] presetData;
  logic        opStrobe, opMem, opToCore, opLong;
  logic [2:0]  opCode, opInfo;
  logic [3:0]  opPrimReg, opSecReg;
  logic [31:0] opAddr, opData, rdq;
  int          checked, mismatches, strobes;

  coproc_link_if link ();
  coproc_core_end coproc_core_end_inst (.clk(clk), .resetn(resetn), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .link(link));
  coproc_unit_end #(.UNIT_NUMBER(UNIT)) coproc_unit_end_inst (.clk(clk), .resetn(resetn),
    .presetWrite(presetWrite), .presetIndex(presetIndex), .presetData(presetData),
    .opStrobe(opStrobe), .opMem(opMem), .opToCore(opToCore), .opCode(opCode), .opInfo(opInfo),
    .opPrimReg(opPrimReg), .opSecReg(opSecReg), .opLong(opLong), .opAddr(opAddr),
    .opData(opData), .link(link));
  coproc_transfer_decode_assertions #(.UNIT_NUMBER(UNIT)) coproc_transfer_decode_assertions_inst (
    .clk(clk), .resetn(resetn), .issueValid(link.issueValid), .memXfer(link.memXfer),
    .dirToCore(link.dirToCore), .unitSel(link.unitSel), .opcode(link.opcode),
    .primReg(link.primReg), .info(link.info), .secReg(link.secReg), .longXfer(link.longXfer),
    .memAddr(link.memAddr), .wrData(link.wrData), .ack(link.ack), .rdData(link.rdData));

  always #25 clk = ~clk;
  always @(posedge clk) if (opStrobe === 1'b1) strobes++;

  function automatic logic [31:0] regOp(input logic [3:0] cond, input logic dir,
      input logic [3:0] primIdx, input logic [3:0] rd, input logic [3:0] unitNum,
      input logic mark);
    return {cond, REG_CLASS, 3'h2, dir, primIdx, rd, unitNum, 3'h5, mark, 4'h6};
  endfunction
  function automatic logic [31:0] memOp(input logic p, input logic u, input logic n,
      input logic w, input logic [3:0] baseIdx, input logic [7:0] imm);
    return {4'hE, MEM_CLASS, p, u, n, w, 1'b0, baseIdx, 4'h2, UNIT, imm};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // read right after the rising edge: the design's updates of that edge have not landed yet
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsRead <= !wr;
    avsWrite <= wr;
    avsAddress <= a;
    avsWritedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 200);
    if (avsWaitrequest !== 1'b0) begin
      mismatches++;
      finish_test();
    end else begin
      rdq = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic setReg(input logic [3:0] i, input logic [31:0] d);
    wr(ADDR_REGIDX, {28'h0, i});
    wr(ADDR_REGDATA, d);
  endtask
  task automatic getReg(input logic [3:0] i);
    wr(ADDR_REGIDX, {28'h0, i});
    rd(ADDR_REGDATA);
  endtask
  task automatic preset(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    presetWrite <= 1'b1;
    presetIndex <= i;
    presetData <= d;
    @(posedge clk);
    presetWrite <= 1'b0;
  endtask
  task automatic issue(input logic [31:0] instr, input logic [3:0] st, input int nStrobe);
    int s0;
    s0 = strobes;
    wr(ADDR_INSTR, instr);
    rd(ADDR_STATUS);
    `CHECK("status", st, rdq[3:0])
    `CHECK("strobes", nStrobe, strobes - s0)
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    avsAddress = 5'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0000_0000;
    presetWrite = 1'b0;
    presetIndex = 4'h0;
    presetData = 32'h0000_0000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    preset(4'h7, 32'h9000_00FF);
    setReg(4'h3, 32'h1234_5678);
    wr(ADDR_PC, 32'h0000_0100);
    issue(regOp(4'hE, 1'b0, 4'h5, 4'h3, UNIT, 1'b1), 4'h1, 1);
    `CHECK("toCore", 1'b0, opToCore)
    `CHECK("opcode", 3'h2, opCode)
    `CHECK("prim", 4'h5, opPrimReg)
    `CHECK("info", 3'h5, opInfo)
    `CHECK("sec", 4'h6, opSecReg)
    `CHECK("word", 32'h1234_5678, opData)
    issue(regOp(4'hE, 1'b0, 4'h5, 4'hF, UNIT, 1'b1), 4'h1, 1);
    `CHECK("pcWord", 32'h0000_010C, opData)
    $display("test to coprocessor done");
    issue(regOp(4'hE, 1'b1, 4'h5, 4'h4, UNIT, 1'b1), 4'h1, 1);
    `CHECK("toCore", 1'b1, opToCore)
    getReg(4'h4);
    `CHECK("reg4", 32'h0000_010C, rdq)
    issue(regOp(4'hE, 1'b1, 4'h7, 4'hF, UNIT, 1'b1), 4'h1, 1);
    rd(ADDR_FLAGS);
    `CHECK("flags", 4'h9, rdq[3:0])
    rd(ADDR_PC);
    `CHECK("pc", 32'h0000_0100, rdq)
    $display("test to core done");
    for (int i = 0; i < 8; i++) begin
      issue(regOp(CONDS[i], 1'b0, 4'h5, 4'h3, UNIT, 1'b1), PASSES[i] ? 4'h1 : 4'h2, int'(PASSES[i]));
    end
    issue(regOp(4'hE, 1'b0, 4'h5, 4'h3, 4'h2, 1'b1), 4'h8, 0);
    issue(regOp(4'hE, 1'b0, 4'h5, 4'h3, UNIT, 1'b0), 4'h4, 0);
    $display("test decode done");
    setReg(4'h5, 32'h0000_1000);
    issue(memOp(1'b1, 1'b1, 1'b1, 1'b1, 4'h5, 8'h06), 4'h1, 1);
    rd(ADDR_XADDR);
    `CHECK("xaddr", 32'h0000_1018, rdq)
    `CHECK("opAddr", 32'h0000_1018, opAddr)
    `CHECK("long", 1'b1, opLong)
    `CHECK("mem", 1'b1, opMem)
    getReg(4'h5);
    `CHECK("base", 32'h0000_1018, rdq)
    issue(memOp(1'b1, 1'b0, 1'b0, 1'b0, 4'h5, 8'h04), 4'h1, 1);
    rd(ADDR_XADDR);
    `CHECK("xaddr", 32'h0000_1008, rdq)
    `CHECK("long", 1'b0, opLong)
    getReg(4'h5);
    `CHECK("base", 32'h0000_1018, rdq)
    issue(memOp(1'b0, 1'b1, 1'b0, 1'b1, 4'h5, 8'h02), 4'h1, 1);
    rd(ADDR_XADDR);
    `CHECK("postAddr", 32'h0000_1018, rdq)
    getReg(4'h5);
    `CHECK("postBase", 32'h0000_1020, rdq)
    issue(memOp(1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 8'h01), 4'h1, 1);
    rd(ADDR_XADDR);
    `CHECK("xaddr", 32'h0000_010C, rdq)
    $display("test memory done");
    finish_test();
  end
endmodule
`default_nettype wire
